// ===== core/line_window.sv
/*
  one pulse window: high from cycle START to START+WIDTH-1 of the line counter.
  assumes the counter runs from zero at the sync edge and saturates.
*/
`timescale 1ns/1ps
module line_window #(
  parameter int unsigned START = 1,
  parameter int unsigned WIDTH = 1
) (
  input  wire logic [10:0] count_in,
  input  wire logic        run_in,
  output logic             hit_out
);

  // ===========================================================
  // window compare
  // upper bound is one bit wider: a window may reach past the saturated count without wrapping
  localparam logic [10:0] LO = 11'(START);
  localparam logic [11:0] HI = 12'(START + WIDTH);

  assign hit_out = run_in && (count_in >= LO) && ({1'b0, count_in} < HI);

endmodule : line_window

// ===== core/panel_line_timing_generator.sv
/*
  line timing generator: per-line strobes for gate driver and source latch,
  timed from horizontal sync or from the data-enable rise.
  assumes sync and data-valid come from the host and are asynchronous to clk_sys_in.
*/
// What this block does
// - drive source outputs for a line 20 pixel clocks after sync edge.
// - line load strobe rises 20 clocks after sync, stays high 10 clocks.
// - new grayscale outputs presented from the rising edge of load strobe.
// - gate start pulse asserted 2 pixel clocks after sync edge.
// - gate shift clock starts 20 clocks after sync, high for 66 clocks.
// - gate output enable starts 4 clocks after sync, high for 74 clocks.
`timescale 1ns/1ps
module panel_line_timing_generator (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsync_in,
  input  wire logic        data_valid_in,
  input  wire logic        mode_de_in,
  input  wire logic [23:0] pixel_data_in,
  output logic             gate_start_pulse_out,
  output logic             gate_shift_clock_out,
  output logic             gate_output_enable_out,
  output logic             line_load_strobe_out,
  output logic             source_drive_out,
  output logic             grayscale_update_out,
  output logic [23:0]      line_data_out,
  output logic             pixel_overrun_out
);

  // ===========================================================
  // input synchronisers
  logic [1:0] hs_sync_q;
  logic [1:0] de_sync_q;
  logic [1:0] mode_sync_q;
  logic       hs_last_q;
  logic       de_last_q;
  logic [23:0] pix_meta_q;
  logic [23:0] pix_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      hs_sync_q   <= 2'h3;
      de_sync_q   <= 2'h0;
      mode_sync_q <= 2'h0;
      pix_meta_q  <= 24'h000000;
      pix_q       <= 24'h000000;
    end
    else
    begin
      hs_sync_q   <= {hs_sync_q[0], hsync_in};
      de_sync_q   <= {de_sync_q[0], data_valid_in};
      mode_sync_q <= {mode_sync_q[0], mode_de_in};
      pix_meta_q  <= pixel_data_in;
      pix_q       <= pix_meta_q;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      hs_last_q <= 1'b1;
      de_last_q <= 1'b0;
    end
    else
    begin
      hs_last_q <= hs_sync_q[1];
      de_last_q <= de_sync_q[1];
    end
  end

  // sync is negative polarity: the falling edge starts the line
  logic hs_edge;
  logic de_edge;
  logic line_start;
  assign hs_edge    = hs_last_q && !hs_sync_q[1];
  assign de_edge    = !de_last_q && de_sync_q[1];
  assign line_start = mode_sync_q[1] ? de_edge : hs_edge;

  // ===========================================================
  // line counter; zero in the cycle after the start edge
  logic [10:0] cnt_q;
  logic        run_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= line_timing_pkg::CNT_RESET;
      run_q <= 1'b0;
    end
    else if (line_start)
    begin
      cnt_q <= 11'h000;
      run_q <= 1'b1;
    end
    else if (cnt_q != line_timing_pkg::CNT_MAX)
    begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // ===========================================================
  // strobe windows; registered below, so a window at count N-1 lands at edge+N
  line_timing_pkg::line_strobes_t win;

  line_window #(.START(line_timing_pkg::START_DELAY - 1), .WIDTH(1)) u_start
  (
    .count_in (cnt_q),
    .run_in   (run_q),
    .hit_out  (win.start)
  );

  line_window #(.START(line_timing_pkg::SHIFT_DELAY - 1),
                .WIDTH(line_timing_pkg::SHIFT_WIDTH)) u_shift
  (
    .count_in (cnt_q),
    .run_in   (run_q),
    .hit_out  (win.shift)
  );

  line_window #(.START(line_timing_pkg::OE_DELAY - 1),
                .WIDTH(line_timing_pkg::OE_WIDTH)) u_oe
  (
    .count_in (cnt_q),
    .run_in   (run_q),
    .hit_out  (win.oe)
  );

  line_window #(.START(line_timing_pkg::LOAD_DELAY - 1),
                .WIDTH(line_timing_pkg::LOAD_WIDTH)) u_load
  (
    .count_in (cnt_q),
    .run_in   (run_q),
    .hit_out  (win.load)
  );

  // source drive stays on until the next line start restarts the counter
  line_window #(.START(line_timing_pkg::SRC_DELAY - 1), .WIDTH(2047)) u_src
  (
    .count_in (cnt_q),
    .run_in   (run_q),
    .hit_out  (win.src_drive)
  );

  line_timing_pkg::line_strobes_t str_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      str_q <= '0;
    end
    else
    begin
      str_q <= win;
    end
  end

  assign gate_start_pulse_out   = str_q.start;
  assign gate_shift_clock_out   = str_q.shift;
  assign gate_output_enable_out = str_q.oe;
  assign line_load_strobe_out   = str_q.load;
  assign source_drive_out       = str_q.src_drive;

  // ===========================================================
  // data register, output latch and grayscale update
  logic [23:0] data_reg_q;
  logic [23:0] latch_q;
  logic        upd_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      data_reg_q <= 24'h000000;
      latch_q    <= 24'h000000;
      upd_q      <= 1'b0;
    end
    else
    begin
      if (de_sync_q[1])
      begin
        data_reg_q <= pix_q;
      end
      if (win.load && !str_q.load)
      begin
        latch_q <= data_reg_q;
      end
      upd_q <= str_q.load && !win.load;
    end
  end

  assign line_data_out        = latch_q;
  assign grayscale_update_out = upd_q;

  // ===========================================================
  // count active pixels; flag a line that is not exactly 800 long
  logic [10:0] pix_cnt_q;
  logic        ovr_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pix_cnt_q <= 11'h000;
      ovr_q     <= 1'b0;
    end
    else
    begin
      if (de_sync_q[1])
      begin
        pix_cnt_q <= pix_cnt_q + 11'h001;
      end
      else if (de_last_q)
      begin
        pix_cnt_q <= 11'h000;
        ovr_q     <= (pix_cnt_q != 11'(line_timing_pkg::ACTIVE_PIXELS));
      end
    end
  end

  assign pixel_overrun_out = ovr_q;

endmodule : panel_line_timing_generator

// ===== pkg/line_timing_pkg.sv
/*
  constants and carrier types for the panel line timing generator.
  assumes all counts are in cycles of the system clock, one pixel per clock.
*/
package line_timing_pkg;

  // ===========================================================
  // timing offsets from the horizontal sync edge, in pixel clocks; then line length, counter and pixel-width constants
  localparam int unsigned SRC_DELAY      = 20;
  localparam int unsigned LOAD_DELAY     = 20;
  localparam int unsigned LOAD_WIDTH     = 10;
  localparam int unsigned START_DELAY    = 2;
  localparam int unsigned SHIFT_DELAY    = 20;
  localparam int unsigned SHIFT_WIDTH    = 66;
  localparam int unsigned OE_DELAY       = 4;
  localparam int unsigned OE_WIDTH       = 74;
  localparam int unsigned ACTIVE_PIXELS  = 800;
  localparam int unsigned CNT_W          = 11;
  localparam logic [10:0] CNT_MAX        = 11'h7ff;
  localparam logic [10:0] CNT_RESET      = 11'h7ff;
  localparam int unsigned PIX_W          = 24;

  // ===========================================================
  // strobes toward gate driver and source latch
  typedef struct packed {
    logic start;
    logic shift;
    logic oe;
    logic load;
    logic src_drive;
  } line_strobes_t;

endpackage : line_timing_pkg

// ===== verif/host_video_model.sv
/*
  host video source: sync pulse, one 800-pixel run, pixel = line position.
  assumes one pixel per clock and the block's reset.
*/
`timescale 1ns/1ps
module host_video_model (
  input  wire logic   clk_sys_in,
  input  wire logic   rst_n_in,
  output logic        hsync_out,
  output logic        data_valid_out,
  output logic [23:0] pixel_out
);
  // =====
  // 900-clock lines; data keeps changing outside the run
  logic [10:0] cnt_q;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      cnt_q <= 11'h00a;
    else if (cnt_q == 11'h383)
      cnt_q <= 11'h000;
    else
      cnt_q <= cnt_q + 11'h001;
  end
  assign hsync_out = (cnt_q >= 11'h00a);
  assign data_valid_out = (cnt_q >= 11'h038) && (cnt_q <= 11'h357);
  assign pixel_out = {13'h0000, cnt_q};
endmodule : host_video_model

// ===== verif/panel_line_timing_generator_sva.sv
/*
  timing checker of the line strobes, offsets from the sampled line edge.
  assumes the two-cycle input synchroniser of the block.
*/
`timescale 1ns/1ps
module line_timing_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        hsync_in,
  input wire logic        data_valid_in,
  input wire logic        mode_de_in,
  input wire logic        gate_start_pulse_out,
  input wire logic        gate_shift_clock_out,
  input wire logic        gate_output_enable_out,
  input wire logic        line_load_strobe_out,
  input wire logic        source_drive_out,
  input wire logic        grayscale_update_out,
  input wire logic [23:0] line_data_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // =====
  // sync and data-enable framing, grayscale update and latch
  chk_start_one_shot: assert property (
    $fell(hsync_in) && !mode_de_in |->
      ##4 !gate_start_pulse_out ##1 gate_start_pulse_out ##1 !gate_start_pulse_out
  ) else $error("start pulse");
  chk_oe_window: assert property (
    $fell(hsync_in) && !mode_de_in |->
      ##6 !gate_output_enable_out ##1 gate_output_enable_out
      ##73 gate_output_enable_out ##1 !gate_output_enable_out
  ) else $error("output enable");
  chk_shift_window: assert property (
    $fell(hsync_in) && !mode_de_in |->
      ##22 !gate_shift_clock_out ##1 gate_shift_clock_out
      ##65 gate_shift_clock_out ##1 !gate_shift_clock_out
  ) else $error("shift clock");
  chk_load_width: assert property (
    $fell(hsync_in) && !mode_de_in |->
      ##23 line_load_strobe_out ##9 line_load_strobe_out ##1 !line_load_strobe_out
  ) else $error("load strobe");
  chk_source_drive: assert property (
    $fell(hsync_in) && !mode_de_in |-> ##23 source_drive_out
  ) else $error("source drive");
  chk_update_at_fall: assert property (
    $fell(line_load_strobe_out) |-> grayscale_update_out
  ) else $error("grayscale update");
  chk_latch_on_load: assert property (
    $changed(line_data_out) |-> $rose(line_load_strobe_out)
  ) else $error("latch change");
  chk_de_framing: assert property (
    $rose(data_valid_in) && mode_de_in |-> ##4 !gate_start_pulse_out ##1 gate_start_pulse_out
  ) else $error("de framing");
endmodule : line_timing_checker
bind panel_line_timing_generator line_timing_checker line_timing_checker_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsync_in(hsync_in),
  .data_valid_in(data_valid_in), .mode_de_in(mode_de_in),
  .gate_start_pulse_out(gate_start_pulse_out), .gate_shift_clock_out(gate_shift_clock_out),
  .gate_output_enable_out(gate_output_enable_out), .line_load_strobe_out(line_load_strobe_out),
  .source_drive_out(source_drive_out), .grayscale_update_out(grayscale_update_out),
  .line_data_out(line_data_out));

// ===== verif/panel_line_timing_generator_tb.sv
/*
  testbench: host model feeds lines, strobes compared cycle by cycle.
  assumes a two-cycle synchroniser ahead of the line counter.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module panel_line_timing_generator_tb;
  logic clk_sys_in, rst_n_in, mode_de_in, hsync, dv, start, shift, oe, load, src, upd, ovr;
  logic [23:0] pix;
  logic [23:0] ldata;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  host_video_model host_video_model_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .hsync_out(hsync), .data_valid_out(dv), .pixel_out(pix));
  panel_line_timing_generator panel_line_timing_generator_i (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .hsync_in(hsync), .data_valid_in(dv), .mode_de_in(mode_de_in),
    .pixel_data_in(pix), .gate_start_pulse_out(start), .gate_shift_clock_out(shift),
    .gate_output_enable_out(oe), .line_load_strobe_out(load), .source_drive_out(src),
    .grayscale_update_out(upd), .line_data_out(ldata), .pixel_overrun_out(ovr));
  function automatic logic win(input int k, input int d, input int w);
    return (k >= d + 2) && (k < d + 2 + w);
  endfunction : win
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // =====
  // mode is only changed while reset holds
  task automatic do_reset(input logic m);
    rst_n_in <= 1'b0;
    mode_de_in <= m;
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (900) @(posedge clk_sys_in);
  endtask : do_reset
  task automatic check_line(input logic m);
    logic [3:0] e;
    do @(posedge clk_sys_in); while ((m ? dv : ~hsync) === 1'b1);
    do @(posedge clk_sys_in); while ((m ? dv : ~hsync) !== 1'b1);
    for (int k = 1; k <= 90; k++)
    begin
      @(posedge clk_sys_in);
      #1;
      e = {win(k, line_timing_pkg::START_DELAY, 1),
           win(k, line_timing_pkg::SHIFT_DELAY, line_timing_pkg::SHIFT_WIDTH),
           win(k, line_timing_pkg::OE_DELAY, line_timing_pkg::OE_WIDTH),
           win(k, line_timing_pkg::LOAD_DELAY, line_timing_pkg::LOAD_WIDTH)};
      `CHK("strobes", e, {start, shift, oe, load})
      `CHK("update", win(k, line_timing_pkg::LOAD_DELAY + line_timing_pkg::LOAD_WIDTH, 1), upd)
      if (k >= line_timing_pkg::SRC_DELAY + 2) `CHK("src", 1'b1, src)
      // de mode: the run is already flowing, so the latch takes the pixel 19 clocks into it
      if (k == 22) `CHK("latch", (m ? 24'h00004b : 24'h000357), ldata)
      if (k == 22) `CHK("overrun", 1'b0, ovr)
    end
    // next stimulus change lands on a clock edge
    @(posedge clk_sys_in);
  endtask : check_line
  task automatic test_sync_mode();
    do_reset(1'b0);
    check_line(1'b0);
    check_line(1'b0);
    $display("test sync mode done");
  endtask : test_sync_mode
  task automatic test_de_mode();
    do_reset(1'b1);
    check_line(1'b1);
    check_line(1'b1);
    $display("test de mode done");
  endtask : test_de_mode
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    rst_n_in = 1'b0;
    mode_de_in = 1'b0;
    test_sync_mode();
    test_de_mode();
    wrap_up();
  end
endmodule : panel_line_timing_generator_tb
